//--- hdl/lsj_strap_mux.sv
// Functional notes
// - Host mode: shared pins form address six..zero
// - Hardware mode: five-bit equalizer code from pins
// - Host mode: interrupt low while alarm raised
// - Global enable cleared suppresses all interrupts
// - Jitter select: off, tx32, rx32, rx64
// - Bandwidth: T1 3 Hz; E1 10 or 1.5
module lsj_strap_mux (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Mode and shared pins
  input  wire logic                config_mode_select,  // High hardware, low host
  input  wire logic [6:0]          shared_pins,         // Seven dual-use pins
  // Line rate and interrupt control
  input  wire logic                line_rate_e1,        // High E1, low T1/J1
  input  wire logic                global_irq_enable,   // Command control enable bit
  input  wire logic                alarm_raised,        // Internal alarm level
  // Host-mode outputs
  output logic [6:0]               host_addr,           // Register address
  output logic                     irq_n,               // Active-low interrupt
  // Hardware-mode outputs
  output logic [4:0]               equalizer_code,      // Equalizer and build-out
  output logic                     jitter_path_select_hi,
  output logic                     jitter_path_select_lo,
  output lsj_pkg::lsj_ja_cfg_t     ja_cfg,              // Decoded attenuator setup
  output logic                     hw_mode              // Registered mode state
);

  logic [8:0] sync_q;  // Synchronised mode, rate and shared pins
  logic       mode_s;
  logic       e1_s;
  logic       gie_s;

  // Static straps move into the core domain first
  lsj_sync #(.W(9)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({config_mode_select, line_rate_e1, shared_pins}),
    .q       (sync_q)
  );

  assign mode_s = sync_q[8];
  assign e1_s   = sync_q[7];
  assign gie_s  = global_irq_enable;

  logic [6:0]           addr_r,  addr_nxt;
  logic [4:0]           eq_r,    eq_nxt;
  logic [1:0]           jsel_r,  jsel_nxt;
  lsj_pkg::lsj_ja_cfg_t cfg_r,   cfg_nxt;
  logic                 irq_n_r, irq_n_nxt;
  logic                 hw_r,    hw_nxt;

  logic [1:0] settle_r;    // Edges seen since reset release, saturating
  logic [1:0] settle_nxt;
  logic       straps_ok;   // Synchroniser output now reflects the pins

  // Straps are trusted only once the synchroniser has refilled after reset;
  // its reset zeros would otherwise read as host mode and could pull the
  // interrupt low for two edges while the board straps hardware mode
  always_comb begin
    settle_nxt = settle_r;
    if (settle_r != 2'(lsj_pkg::SYNC_STAGES)) begin
      // Still refilling
      settle_nxt = settle_r + 2'h1;
    end
  end

  // Register the settle count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_r <= 2'h0;
    end else begin
      settle_r <= settle_nxt;
    end
  end

  assign straps_ok = (settle_r == 2'(lsj_pkg::SYNC_STAGES));

  // Decode the shared pins according to the mode
  always_comb begin
    hw_nxt   = 1'b0;
    addr_nxt = lsj_pkg::ADDR_RST;
    eq_nxt   = lsj_pkg::EQ_RST;
    jsel_nxt = lsj_pkg::JSEL_OFF;
    if (!straps_ok) begin
      // Synchroniser still refilling: keep the reset picture
      hw_nxt = 1'b0;
    end else if (!mode_s) begin
      // Host: pins are the address bus
      addr_nxt = sync_q[6:0];
    end else begin
      // Hardware: top two pins select jitter path, rest equalizer
      hw_nxt   = 1'b1;
      jsel_nxt = sync_q[lsj_pkg::JSEL_HI_POS:lsj_pkg::JSEL_LO_POS];
      eq_nxt   = sync_q[lsj_pkg::EQ_MSB_POS:0];
    end
  end

  // Jitter attenuator configuration from the select code
  always_comb begin
    cfg_nxt = '{path: lsj_pkg::LSJ_PATH_OFF, fifo_64: 1'b0, bw_dhz: 8'h00};
    unique case (jsel_nxt)
      lsj_pkg::JSEL_OFF: begin
        cfg_nxt.path = lsj_pkg::LSJ_PATH_OFF;
      end
      lsj_pkg::JSEL_TX32: begin
        cfg_nxt.path   = lsj_pkg::LSJ_PATH_TX;
        cfg_nxt.bw_dhz = e1_s ? lsj_pkg::BW_E1_32_DHZ : lsj_pkg::BW_T1_DHZ;
      end
      lsj_pkg::JSEL_RX32: begin
        cfg_nxt.path   = lsj_pkg::LSJ_PATH_RX;
        cfg_nxt.bw_dhz = e1_s ? lsj_pkg::BW_E1_32_DHZ : lsj_pkg::BW_T1_DHZ;
      end
      lsj_pkg::JSEL_RX64: begin
        cfg_nxt.path    = lsj_pkg::LSJ_PATH_RX;
        cfg_nxt.fifo_64 = 1'b1;
        cfg_nxt.bw_dhz  = e1_s ? lsj_pkg::BW_E1_64_DHZ : lsj_pkg::BW_T1_DHZ;
      end
    endcase
  end

  // Interrupt: low only in settled host mode with alarm and enable
  // The enable gate wins over a raised alarm
  always_comb begin
    irq_n_nxt = !(straps_ok && !mode_s && gie_s && alarm_raised);
  end

  // Register all outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_r  <= lsj_pkg::ADDR_RST;
      eq_r    <= lsj_pkg::EQ_RST;
      jsel_r  <= lsj_pkg::JSEL_OFF;
      cfg_r   <= '{path: lsj_pkg::LSJ_PATH_OFF, fifo_64: 1'b0, bw_dhz: 8'h00};
      irq_n_r <= 1'b1;
      hw_r    <= 1'b0;
    end else begin
      addr_r  <= addr_nxt;
      eq_r    <= eq_nxt;
      jsel_r  <= jsel_nxt;
      cfg_r   <= cfg_nxt;
      irq_n_r <= irq_n_nxt;
      hw_r    <= hw_nxt;
    end
  end

  assign host_addr             = addr_r;
  assign equalizer_code        = eq_r;
  assign jitter_path_select_hi = jsel_r[1];
  assign jitter_path_select_lo = jsel_r[0];
  assign ja_cfg                = cfg_r;
  assign irq_n                 = irq_n_r;
  assign hw_mode               = hw_r;

  // Checks
  // Host mode passes the synchronised pins through as the address
  chk_addr_host: assert property (@(posedge clk_sys) disable iff (rst)
    !hw_r |-> host_addr == $past(sync_q[6:0]))
    else $error("host address wrong");
  // Hardware mode passes the low five pins through as the equalizer code
  chk_eq_hw: assert property (@(posedge clk_sys) disable iff (rst)
    hw_r |-> equalizer_code == $past(sync_q[4:0]))
    else $error("eq code wrong");
  // Enabled alarm in settled host mode pulls the interrupt low
  chk_irq_fire: assert property (@(posedge clk_sys) disable iff (rst)
    (straps_ok && !mode_s && gie_s && alarm_raised) |=> !irq_n)
    else $error("irq missing");
  // Hardware mode never shows an interrupt
  chk_irq_hw: assert property (@(posedge clk_sys) disable iff (rst)
    hw_r |-> irq_n)
    else $error("irq in hardware mode");
  // Cleared global enable keeps the interrupt released
  chk_irq_gated: assert property (@(posedge clk_sys) disable iff (rst)
    !gie_s |=> irq_n)
    else $error("irq not gated");
  // Disabled code leaves the attenuator off
  chk_ja_off: assert property (@(posedge clk_sys) disable iff (rst)
    (jsel_r == lsj_pkg::JSEL_OFF) |-> ja_cfg.path == lsj_pkg::LSJ_PATH_OFF)
    else $error("ja not off");
  // Transmit code places the attenuator in transmit with the short FIFO
  chk_ja_tx: assert property (@(posedge clk_sys) disable iff (rst)
    (jsel_r == lsj_pkg::JSEL_TX32) |-> ja_cfg.path == lsj_pkg::LSJ_PATH_TX && !ja_cfg.fifo_64)
    else $error("tx32 wrong");
  // Deep receive code selects the receive path with the long FIFO
  chk_ja_rx64: assert property (@(posedge clk_sys) disable iff (rst)
    (jsel_r == lsj_pkg::JSEL_RX64) |-> ja_cfg.fifo_64 && ja_cfg.path == lsj_pkg::LSJ_PATH_RX)
    else $error("rx64 wrong");
  // T1 bandwidth in every enabled code
  chk_bw_t1: assert property (@(posedge clk_sys) disable iff (rst)
    (jsel_nxt != lsj_pkg::JSEL_OFF && !e1_s) |=> ja_cfg.bw_dhz == lsj_pkg::BW_T1_DHZ)
    else $error("t1 bw wrong");
  // E1 with the long FIFO narrows the loop bandwidth
  chk_bw_e1: assert property (@(posedge clk_sys) disable iff (rst)
    (jsel_nxt == lsj_pkg::JSEL_RX64 && e1_s) |=> ja_cfg.bw_dhz == lsj_pkg::BW_E1_64_DHZ)
    else $error("e1 bw wrong");
  // Mode pin reaches the mode output three edges later
  chk_sync_lag: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(config_mode_select) ##0 1[*1] |-> ##3 hw_mode == $past(config_mode_select, 3))
    else $error("mode lag wrong");
  // Outputs keep the reset picture until the synchroniser has refilled
  chk_settle_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !straps_ok |=> irq_n && !hw_mode && host_addr == lsj_pkg::ADDR_RST)
    else $error("settle not held");

  // Scenario covers
  cov_host_irq: cover property (@(posedge clk_sys) disable iff (rst) !hw_r && !irq_n);
  cov_hw_tx: cover property (@(posedge clk_sys) disable iff (rst)
    ja_cfg.path == lsj_pkg::LSJ_PATH_TX);
  cov_hw_rx32: cover property (@(posedge clk_sys) disable iff (rst)
    ja_cfg.path == lsj_pkg::LSJ_PATH_RX && !ja_cfg.fifo_64);
  cov_hw_e1_64: cover property (@(posedge clk_sys) disable iff (rst)
    ja_cfg.bw_dhz == lsj_pkg::BW_E1_64_DHZ);

endmodule : lsj_strap_mux

//--- hdl/lsj_pkg.sv
package lsj_pkg;

  // Shared pin field layout
  localparam int ADDR_W       = 7;  // Host address width
  localparam int EQ_W         = 5;  // Equalizer code width
  localparam int JSEL_W       = 2;  // Jitter select width
  localparam int JSEL_HI_POS  = 6;  // Jitter select high bit
  localparam int JSEL_LO_POS  = 5;  // Jitter select low bit
  localparam int EQ_MSB_POS   = 4;  // Equalizer code top bit
  localparam int SYNC_STAGES  = 2;  // Strap synchroniser depth

  // Reset values
  localparam logic [6:0] ADDR_RST = 7'h00;  // Address after reset
  localparam logic [4:0] EQ_RST   = 5'h00;  // Equalizer after reset

  // Jitter select codes
  localparam logic [1:0] JSEL_OFF   = 2'h0;  // Attenuator disabled
  localparam logic [1:0] JSEL_TX32  = 2'h1;  // Transmit, 32-bit FIFO
  localparam logic [1:0] JSEL_RX32  = 2'h2;  // Receive, 32-bit FIFO
  localparam logic [1:0] JSEL_RX64  = 2'h3;  // Receive, 64-bit FIFO

  // Loop bandwidth in tenths of a hertz
  localparam logic [7:0] BW_T1_DHZ     = 8'h1e;  // 3 Hz
  localparam logic [7:0] BW_E1_32_DHZ  = 8'h64;  // 10 Hz
  localparam logic [7:0] BW_E1_64_DHZ  = 8'h0f;  // 1.5 Hz

  // Jitter attenuator path
  typedef enum logic [1:0] {
    LSJ_PATH_OFF,
    LSJ_PATH_TX,
    LSJ_PATH_RX
  } lsj_path_t;

  // Attenuator configuration bundle
  typedef struct packed {
    lsj_path_t  path;      // Placement
    logic       fifo_64;   // FIFO depth 64 when set, else 32
    logic [7:0] bw_dhz;    // Loop bandwidth, tenths of a hertz
  } lsj_ja_cfg_t;

endpackage : lsj_pkg

//--- hdl/lsj_sync.sv
// Two flop level synchroniser for static straps
module lsj_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;  // First stage, read only by second
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;     // Second stage
  logic [W-1:0] q_nxt;

  // Next values of both stages
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Register both stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule : lsj_sync

//--- tb/lsj_strap_model.sv
// Board strap side: drives the mode pin and the seven shared pins
module lsj_strap_model (
  // Requests from the bench
  input  wire logic       hw_req,       // Strap mode pin high
  input  wire logic       open_req,     // Leave mode pin unconnected
  input  wire logic [6:0] pin_req,      // Shared pin levels or address
  // Pins towards the device
  output logic            config_mode_select,
  output logic [6:0]      shared_pins,
  // Master clock pins, fed from a single E1 source
  output logic            e1_master_clock_in,
  output logic            t1_master_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // An open mode pin floats to its pull-up, which selects hardware mode
  assign config_mode_select = open_req ? 1'b1 : hw_req;
  // Shared pins are always driven by the board or the host bus
  assign shared_pins        = pin_req;

  // 2.048 MHz reference at 50 percent duty, well inside 50 ppm
  localparam real MCLK_HALF = 244.141;  // Half period in ns
  logic           mclk_r    = 1'b0;     // Free-running board clock source
  always #(MCLK_HALF) mclk_r = ~mclk_r;
  // The one source drives both master clock inputs
  assign e1_master_clock_in = mclk_r;
  assign t1_master_clock_in = mclk_r;
endmodule : lsj_strap_model

//--- tb/tb_top.sv
// Self-checking bench for the strap and jitter select decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and stimulus
  logic                 clk_sys = 1'b0;
  logic                 rst = 1'b1;
  logic                 hw_req = 1'b0, open_req = 1'b0;
  logic [6:0]           pin_req = 7'h00;
  logic                 line_rate_e1 = 1'b0, global_irq_enable = 1'b0, alarm_raised = 1'b0;
  // Pins and outputs
  logic                 config_mode_select, irq_n, jhi, jlo, hw_mode;
  logic [6:0]           shared_pins, host_addr;
  logic [4:0]           eq_code;
  lsj_pkg::lsj_ja_cfg_t ja_cfg;
  // Scoreboard
  int                   num_errors = 0, checks = 0;
  int                   seed = 32'he068e97c;
  logic [31:0]          r;
  logic [26:0]          exp_q[$];
  event                 chk_ev;
  logic                 e1_mclk, t1_mclk;  // Master clock pins from the board model
  realtime              t_edge;            // Last master clock rising edge

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  lsj_strap_model strap_u (.hw_req(hw_req), .open_req(open_req), .pin_req(pin_req),
    .config_mode_select(config_mode_select), .shared_pins(shared_pins),
    .e1_master_clock_in(e1_mclk), .t1_master_clock_in(t1_mclk));

  lsj_strap_mux dut_u (.clk_sys(clk_sys), .rst(rst), .config_mode_select(config_mode_select),
    .shared_pins(shared_pins), .line_rate_e1(line_rate_e1),
    .global_irq_enable(global_irq_enable), .alarm_raised(alarm_raised),
    .host_addr(host_addr), .irq_n(irq_n), .equalizer_code(eq_code),
    .jitter_path_select_hi(jhi), .jitter_path_select_lo(jlo), .ja_cfg(ja_cfg),
    .hw_mode(hw_mode));

  // Expected output vector for one static input setting
  function automatic logic [26:0] exp_of(input logic hw, e1, en, al, input logic [6:0] p);
    lsj_pkg::lsj_ja_cfg_t c;
    c = '0;
    // Host mode: pins are the address, hardware fields stay zero
    if (!hw) return {p, ~(en & al), 19'h00000};
    c.path = (p[6:5] === lsj_pkg::JSEL_OFF) ? lsj_pkg::LSJ_PATH_OFF :
             (p[6:5] === lsj_pkg::JSEL_TX32) ? lsj_pkg::LSJ_PATH_TX : lsj_pkg::LSJ_PATH_RX;
    c.fifo_64 = (p[6:5] === lsj_pkg::JSEL_RX64);
    // Bandwidth only when the attenuator is in use
    if (p[6:5] !== lsj_pkg::JSEL_OFF)
      c.bw_dhz = !e1 ? lsj_pkg::BW_T1_DHZ :
                 c.fifo_64 ? lsj_pkg::BW_E1_64_DHZ : lsj_pkg::BW_E1_32_DHZ;
    return {7'h00, 1'b1, p[4:0], p[6], p[5], c, 1'b1};
  endfunction : exp_of

  // Compare one output vector
  task automatic cmp_out(input logic [26:0] act, input logic [26:0] exp);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : cmp_out

  // Compare one master clock observation
  task automatic cmp_clk(input logic act, input logic exp);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : cmp_clk

  // One master clock period against 2.048 MHz within 50 ppm
  initial begin
    @(posedge e1_mclk);
    t_edge = $realtime;
    @(posedge e1_mclk);
    cmp_clk(($realtime - t_edge) > 488.257 && ($realtime - t_edge) < 488.305, 1'b1);
  end

  // Drive a setting, note the result, then let the synchroniser settle
  task automatic apply(input logic hw, op, e1, en, al, input logic [6:0] p);
    @(posedge clk_sys);
    hw_req <= hw;
    open_req <= op;
    pin_req <= p;
    line_rate_e1 <= e1;
    global_irq_enable <= en;
    alarm_raised <= al;
    exp_q.push_back(exp_of(hw | op, e1, en, al, p));
    repeat (4) @(posedge clk_sys);
    #1 -> chk_ev;
  endtask : apply

  // Monitor: oldest note against the outputs
  initial forever begin
    @(chk_ev);
    cmp_out({host_addr, irq_n, eq_code, jhi, jlo, ja_cfg, hw_mode}, exp_q.pop_front());
    cmp_clk(t1_mclk, e1_mclk);
  end

  // Verdict and end of run
  task automatic close_out;
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // Every jitter code at both line rates
    for (int c = 0; c < 8; c++) apply(1'b1, 1'b0, c[2], 1'b0, 1'b1, {c[1:0], 5'h13});
    apply(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 7'h7f);
    // Interrupt gate in host mode, then in hardware mode
    for (int k = 0; k < 4; k++) apply(1'b0, 1'b0, 1'b0, k[1], k[0], 7'h5a);
    apply(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 7'h2c);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      apply(r[0], 1'b0, r[8], r[9], r[10], r[7:1]);
    end
    // Hardware mode with an enabled alarm, so a false interrupt would show
    apply(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 7'h33);
    // Reset in mid-run clears outputs and releases the interrupt
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    exp_q.push_back({7'h00, 1'b1, 19'h00000});
    #1 -> chk_ev;
    @(posedge clk_sys);
    rst <= 1'b0;
    // First two edges after release: reset picture while the straps refill
    repeat (2) begin
      @(posedge clk_sys);
      exp_q.push_back({7'h00, 1'b1, 19'h00000});
      #1 -> chk_ev;
    end
    apply(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 7'h41);
    close_out;
  end

  // Watchdog
  initial begin
    #200000;
    num_errors++;
    close_out;
  end
endmodule : tb_top
